// file: bench/hpsc_link_sva.sv
// assertions on the link between slot controller and sequencer
`timescale 1ns/10ps
module hpsc_link_sva #(
  parameter int REG_CYCLES = 50,
  parameter int CLR_CYCLES = 10,
  parameter int RAMP_CYCLES = 5,
  parameter int DELAY_CYCLES = 5
) (
  input wire logic i_clock, // clock
  input wire logic i_resetn, // async reset, active low
  input wire logic [1:0] main_power_request, // request per slot
  input wire logic [1:0] slot_aux_switch_n, // slot switch, low closed
  input wire logic [1:0] main_fault, // main latch
  input wire logic [1:0] aux_fault, // aux latch
  input wire logic [1:0] regulating, // regulation latch
  input wire logic [1:0] gated_wake_event_oe // wake node pull
);
  localparam int REG_LIM = REG_CYCLES + CLR_CYCLES + 2;
  localparam int WAKE_MIN = RAMP_CYCLES + DELAY_CYCLES;
  int closed_cnt;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // slot 0 only: slot 1 is a copy and the counter costs lines
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      closed_cnt <= 0;
    end else if (slot_aux_switch_n[0]) begin
      closed_cnt <= 0;
    end else if (closed_cnt < WAKE_MIN) begin
      closed_cnt <= closed_cnt + 1;
    end
  end
  a_fault_holds: assert property (1 |=>
    ($past(main_fault & main_power_request) & ~main_fault) == 2'h0) else $error("fault lost");
  a_fault_clears: assert property ((main_fault & ~main_power_request) != 2'h0 |=>
    ($past(main_fault & ~main_power_request) & main_fault) == 2'h0) else $error("fault stuck");
  a_aux_open_clear: assert property (1 |=>
    (aux_fault & $past(slot_aux_switch_n)) == 2'h0) else $error("aux fault stuck");
  a_wake_open_off: assert property (1 |=>
    (gated_wake_event_oe & $past(slot_aux_switch_n)) == 2'h0) else $error("wake on, switch open");
  a_wake_fault_off: assert property ((gated_wake_event_oe & aux_fault) == 2'h0)
    else $error("wake on during aux fault");
  a_wake_delay: assert property (gated_wake_event_oe[0] |-> closed_cnt >= WAKE_MIN)
    else $error("wake connected early");
  a_aux_trip_closed: assert property ($rose(aux_fault[0]) |-> !$past(slot_aux_switch_n[0]))
    else $error("aux fault with switch open");
  a_reg_bounded: assert property ($rose(regulating[0]) |->
    ##[1:REG_LIM] (main_fault[0] || !regulating[0])) else $error("regulation overran");
  c_main_fault: cover property ($rose(main_fault[0]));
  c_aux_fault: cover property ($rose(aux_fault[0]));
  c_wake_on: cover property ($rose(gated_wake_event_oe[0]));
endmodule

// file: bench/test_hotplug_slot_fault_pme_control.sv
// self-checking bench: controller and sequencer joined across the link
`timescale 1ns/10ps
`define CK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h want %h", $time, g, e); end end
module test_hotplug_slot_fault_pme_control;
  import hpsc_pkg::*;
  localparam int REG = 50;
  localparam int CLR = 10;
  localparam int RMP = 5;
  localparam int DLY = 5;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hready, hresp, irq;
  logic rd_pend = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, want;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [1:0] ovl = 2'h0, oc12 = 2'h0, ocn12 = 2'h0, auxoc = 2'h0, wk_n = 2'h3;
  logic aux_good = 1'b1;
  logic [1:0] men, gred, lowg, highg, r12, auxo;
  logic [31:0] expq[$];
  int err_total = 0;
  int checked = 0;
  hpsc_if link ();
  hpsc_device #(.REG_CYCLES(REG), .CLR_CYCLES(CLR), .RAMP_CYCLES(RMP), .DELAY_CYCLES(DLY))
    u_hpsc_device (.i_clock(i_clock), .i_resetn(i_resetn), .link(link), .i_main_overload(ovl),
    .i_rail12_oc(oc12), .i_rail_n12_oc(ocn12), .i_aux_oc(auxoc), .i_slot_wake_event_in_n(wk_n),
    .i_aux_supply_good(aux_good), .o_main_enable(men), .o_gate_reduce(gred),
    .o_low_io_gate_drive(lowg), .o_high_io_gate_drive(highg), .o_rail12_enable(r12),
    .o_slot_aux_output(auxo));
  hpsc_host u_hpsc_host (.i_clock(i_clock), .i_resetn(i_resetn), .link(link), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp), .o_irq(irq));
  hpsc_link_sva #(.REG_CYCLES(REG), .CLR_CYCLES(CLR), .RAMP_CYCLES(RMP), .DELAY_CYCLES(DLY))
    u_hpsc_link_sva (.i_clock(i_clock), .i_resetn(i_resetn),
    .main_power_request(link.main_power_request), .slot_aux_switch_n(link.slot_aux_switch_n),
    .main_fault(link.main_fault), .aux_fault(link.aux_fault), .regulating(link.regulating),
    .gated_wake_event_oe(link.gated_wake_event_oe));
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  // read data is judged at the edge that ends its data phase
  always @(posedge i_clock) begin
    if (rd_pend && hready) begin
      want = expq.pop_front();
      `CK(hrdata, want)
      `CK(hresp, 1'b0)
    end
    if (hready) rd_pend <= hsel && htrans[1] && !hwrite;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    ahb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  initial begin
    logic [31:0] r;
    int m;
    void'($urandom(52));
    tick(2);
    i_resetn <= 1'b1;
    tick(1);
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_STATUS, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'hFFFF_FFFF);
    rd(OFS_IRQ_MASK, 32'h0000_001F);
    r = $urandom() & 32'h0000_0333;
    wr(OFS_CTRL, r);
    rd(OFS_CTRL, r);
    wr(8'h10, r);
    rd(8'h10, 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    $display("test registers done");
    for (m = 0; m < 5; m++) begin
      wr(OFS_CTRL, 32'h0000_0003 | (m << CTRL_MODE0_LSB) | ((4 - m) << CTRL_MODE1_LSB));
      tick(4);
      `CK(men, 2'h3)
      `CK(lowg, {m <= 1, m >= 3})
      `CK(highg, ~{m <= 1, m >= 3})
    end
    wr(OFS_CTRL, 32'h0000_0000);
    tick(4);
    `CK({men, lowg | highg}, 4'h0)
    $display("test io select done");
    wr(OFS_CTRL, 32'h0000_0003);
    tick(4);
    ovl <= 2'h1;
    tick(6);
    `CK({gred, link.regulating}, 4'h5)
    ovl <= 2'h0;
    tick(CLR + 3);
    `CK({link.regulating, men}, 4'h3)
    ovl <= 2'h1;
    tick(REG - 4);
    `CK(link.main_fault, 2'h0)
    tick(8);
    `CK({link.main_fault, men, r12, lowg | highg}, 8'h6A)
    rd(OFS_IRQ_STATUS, 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    tick(2);
    `CK(irq, 1'b1)
    wr(OFS_IRQ_STATUS, 32'h0000_0001);
    tick(2);
    `CK(irq, 1'b0)
    ovl <= 2'h0;
    tick(4);
    `CK(link.main_fault, 2'h1)
    wr(OFS_CTRL, 32'h0000_0002);
    tick(4);
    `CK(link.main_fault, 2'h0)
    wr(OFS_CTRL, 32'h0000_0003);
    tick(4);
    `CK(men, 2'h3)
    $display("test regulation done");
    for (m = 0; m < 2; m++) begin
      if (m == 0) oc12 <= 2'h2;
      else ocn12 <= 2'h2;
      tick(1);
      oc12 <= 2'h0;
      ocn12 <= 2'h0;
      tick(FAST_TRIP_CYCLES - 5);
      `CK(r12, 2'h3)
      tick(10);
      `CK({link.main_fault, r12, men}, 6'h25)
      wr(OFS_CTRL, 32'h0000_0001);
      tick(4);
      wr(OFS_CTRL, 32'h0000_0003);
      tick(4);
      `CK({link.main_fault, men}, 4'h3)
    end
    wr(OFS_IRQ_STATUS, 32'h0000_001F);
    $display("test fast trip done");
    wk_n <= 2'h2;
    wr(OFS_CTRL, 32'h0000_0004);
    tick(4);
    `CK({auxo, link.gated_wake_event_oe}, 4'h4)
    tick(RMP + DLY + 4);
    `CK({link.gated_wake_event_oe, link.wake_bus_n}, 3'h2)
    rd(OFS_STATUS, 32'h0000_0040);
    // wake path follows the card one cycle later once connected
    repeat (6) begin
      r = $urandom();
      wk_n <= {1'b1, r[0]};
      tick(2);
      `CK(link.gated_wake_event_oe, {1'b0, ~r[0]})
    end
    rd(OFS_IRQ_STATUS, 32'h0000_0010);
    auxoc <= 2'h1;
    tick(1);
    auxoc <= 2'h0;
    tick(FAST_TRIP_CYCLES + 5);
    `CK({link.aux_fault, auxo, link.gated_wake_event_oe}, 6'h10)
    wr(OFS_CTRL, 32'h0000_0000);
    tick(4);
    `CK(link.aux_fault, 2'h0)
    wr(OFS_CTRL, 32'h0000_0004);
    tick(4);
    auxoc <= 2'h1;
    tick(1);
    auxoc <= 2'h0;
    tick(FAST_TRIP_CYCLES + 5);
    `CK(link.aux_fault, 2'h1)
    aux_good <= 1'b0;
    tick(3);
    `CK(link.aux_fault, 2'h0)
    aux_good <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0000);
    $display("test aux and wake done");
    tally_and_finish();
  end
endmodule

// file: hw/hpsc_device.sv
// per-slot fault timers, latches, io-voltage steering and aux/wake sequencing
`timescale 1ns/10ps
module hpsc_device #(
  parameter int REG_CYCLES = hpsc_pkg::REG_HOLD_CYCLES,
  parameter int CLR_CYCLES = hpsc_pkg::REG_CLEAR_CYCLES,
  parameter int RAMP_CYCLES = hpsc_pkg::AUX_RAMP_CYCLES,
  parameter int DELAY_CYCLES = hpsc_pkg::WAKE_DELAY_CYCLES
) (
  input wire logic i_clock, // 125 MHz clock
  input wire logic i_resetn, // async reset, active low
  hpsc_if.device link, // slot controller side
  input wire logic [hpsc_pkg::NSLOT-1:0] i_main_overload, // 3.3V/5V/io overload sensed
  input wire logic [hpsc_pkg::NSLOT-1:0] i_rail12_oc, // 12 V overcurrent sensed
  input wire logic [hpsc_pkg::NSLOT-1:0] i_rail_n12_oc, // -12 V overcurrent sensed
  input wire logic [hpsc_pkg::NSLOT-1:0] i_aux_oc, // 3.3 V aux overcurrent sensed
  input wire logic [hpsc_pkg::NSLOT-1:0] i_slot_wake_event_in_n, // card wake event, low
  input wire logic i_aux_supply_good, // aux supply to this part present
  output logic [hpsc_pkg::NSLOT-1:0] o_main_enable, // main supply gates ramp up
  output logic [hpsc_pkg::NSLOT-1:0] o_gate_reduce, // gate drive lowered, regulating
  output logic [hpsc_pkg::NSLOT-1:0] o_low_io_gate_drive, // 1.5 V io gate on
  output logic [hpsc_pkg::NSLOT-1:0] o_high_io_gate_drive, // 3.3 V io gate on
  output logic [hpsc_pkg::NSLOT-1:0] o_rail12_enable, // 12 V and -12 V switches on
  output logic [hpsc_pkg::NSLOT-1:0] o_slot_aux_output // 3.3 V aux switch on
);
  import hpsc_pkg::*;

  typedef enum logic [1:0] {
    AUX_OFF,
    AUX_RAMP,
    AUX_WAIT,
    AUX_ON
  } hpsc_aux_e;

  typedef logic [CNT_W-1:0] hpsc_cnt_t;

  if (REG_CYCLES < 1 || REG_CYCLES > (1 << CNT_W) - 1) begin : g_chk_reg
    $error("REG_CYCLES out of range");
  end
  if (CLR_CYCLES < 1 || CLR_CYCLES > (1 << CNT_W) - 1) begin : g_chk_clr
    $error("CLR_CYCLES out of range");
  end
  if (RAMP_CYCLES < 1 || RAMP_CYCLES > (1 << CNT_W) - 1) begin : g_chk_ramp
    $error("RAMP_CYCLES out of range");
  end
  if (DELAY_CYCLES < 1 || DELAY_CYCLES > (1 << CNT_W) - 1) begin : g_chk_delay
    $error("DELAY_CYCLES out of range");
  end

  function automatic hpsc_cnt_t cnt_inc(input hpsc_cnt_t c);
    cnt_inc = c + hpsc_cnt_t'(1);
  endfunction

  function automatic logic cnt_last(input hpsc_cnt_t c, input int limit);
    cnt_last = (c == hpsc_cnt_t'(limit - 1));
  endfunction

  logic [NSLOT-1:0] reg_mode;
  hpsc_cnt_t reg_cnt [NSLOT];
  hpsc_cnt_t clr_cnt [NSLOT];
  hpsc_cnt_t rail_cnt [NSLOT];
  hpsc_cnt_t aux_oc_cnt [NSLOT];
  hpsc_cnt_t aux_cnt [NSLOT];
  hpsc_aux_e aux_state [NSLOT];
  logic [NSLOT-1:0] main_fault;
  logic [NSLOT-1:0] aux_fault;
  logic [NSLOT-1:0] wake_oe;
  logic [NSLOT-1:0] reg_expire;
  logic [NSLOT-1:0] rail_trip;
  logic [NSLOT-1:0] aux_trip;
  logic [NSLOT-1:0] main_on;
  logic [NSLOT-1:0] aux_kill;

  // trip pulses and gating terms; every index is one slot only
  always_comb begin
    for (int s = 0; s < NSLOT; s++) begin
      reg_expire[s] = reg_mode[s] & i_main_overload[s] & cnt_last(reg_cnt[s], REG_CYCLES);
      rail_trip[s] = cnt_last(rail_cnt[s], FAST_TRIP_CYCLES);
      aux_trip[s] = cnt_last(aux_oc_cnt[s], FAST_TRIP_CYCLES) & ~link.slot_aux_switch_n[s];
      main_on[s] = link.main_power_request[s] & ~main_fault[s] & ~aux_fault[s];
      aux_kill[s] = link.slot_aux_switch_n[s] | aux_fault[s] | aux_trip[s];
    end
  end

  // regulation latch, 5 ms hold timer and 100 us release timer
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      reg_mode <= '0;
      for (int s = 0; s < NSLOT; s++) begin
        reg_cnt[s] <= '0;
        clr_cnt[s] <= '0;
      end
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        if (!main_on[s]) begin
          // slot off: nothing to regulate, start clean next time
          reg_mode[s] <= 1'b0;
          reg_cnt[s] <= '0;
          clr_cnt[s] <= '0;
        end else if (i_main_overload[s]) begin
          reg_mode[s] <= 1'b1;
          clr_cnt[s] <= '0;
          if (reg_mode[s] && !cnt_last(reg_cnt[s], REG_CYCLES)) begin
            reg_cnt[s] <= cnt_inc(reg_cnt[s]);
          end
        end else if (reg_mode[s]) begin
          if (cnt_last(clr_cnt[s], CLR_CYCLES)) begin
            reg_mode[s] <= 1'b0;
            reg_cnt[s] <= '0;
            clr_cnt[s] <= '0;
          end else begin
            clr_cnt[s] <= cnt_inc(clr_cnt[s]);
          end
        end
      end
    end
  end

  // fast trips: once a fault is seen the 3 us count runs to the end while that slot's supply stays switched on
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int s = 0; s < NSLOT; s++) begin
        rail_cnt[s] <= '0;
        aux_oc_cnt[s] <= '0;
      end
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        if (rail_trip[s]) begin
          rail_cnt[s] <= '0;
        end else if (main_on[s] && (i_rail12_oc[s] || i_rail_n12_oc[s] || rail_cnt[s] != '0)) begin
          rail_cnt[s] <= cnt_inc(rail_cnt[s]);
        end else begin
          rail_cnt[s] <= '0;
        end
        if (aux_trip[s]) begin
          aux_oc_cnt[s] <= '0;
        end else if (!aux_kill[s] && (i_aux_oc[s] || aux_oc_cnt[s] != '0)) begin
          aux_oc_cnt[s] <= cnt_inc(aux_oc_cnt[s]);
        end else begin
          aux_oc_cnt[s] <= '0;
        end
      end
    end
  end

  // main fault latch: only dropping the request releases it; set wins
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      main_fault <= '0;
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        if (reg_expire[s] || rail_trip[s]) begin
          main_fault[s] <= 1'b1;
        end else if (!link.main_power_request[s]) begin
          main_fault[s] <= 1'b0;
        end
      end
    end
  end

  // aux fault latch: cleared by an open switch or loss of aux supply
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      aux_fault <= '0;
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        if (aux_trip[s]) begin
          aux_fault[s] <= 1'b1;
        end else if (link.slot_aux_switch_n[s] || !i_aux_supply_good) begin
          aux_fault[s] <= 1'b0;
        end
      end
    end
  end

  // aux ramp then wake delay; main request and main faults play no part
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int s = 0; s < NSLOT; s++) begin
        aux_state[s] <= AUX_OFF;
        aux_cnt[s] <= '0;
      end
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        if (aux_kill[s]) begin
          aux_state[s] <= AUX_OFF;
          aux_cnt[s] <= '0;
        end else begin
          case (aux_state[s])
            AUX_OFF: begin
              aux_state[s] <= AUX_RAMP;
              aux_cnt[s] <= '0;
            end
            AUX_RAMP: begin
              if (cnt_last(aux_cnt[s], RAMP_CYCLES)) begin
                aux_state[s] <= AUX_WAIT;
                aux_cnt[s] <= '0;
              end else begin
                aux_cnt[s] <= cnt_inc(aux_cnt[s]);
              end
            end
            AUX_WAIT: begin
              if (cnt_last(aux_cnt[s], DELAY_CYCLES)) begin
                aux_state[s] <= AUX_ON;
                aux_cnt[s] <= '0;
              end else begin
                aux_cnt[s] <= cnt_inc(aux_cnt[s]);
              end
            end
            AUX_ON: begin
              aux_state[s] <= AUX_ON;
            end
            default: begin
              aux_state[s] <= AUX_OFF;
              aux_cnt[s] <= '0;
            end
          endcase
        end
      end
    end
  end

  // aux switch and wake gate outputs
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_slot_aux_output <= '0;
      wake_oe <= '0;
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        o_slot_aux_output[s] <= ~aux_kill[s];
        // pull the shared node only while connected and the card asserts
        wake_oe[s] <= (aux_state[s] == AUX_ON) & ~aux_kill[s] & ~i_slot_wake_event_in_n[s];
      end
    end
  end

  // main supply and io gate outputs
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_main_enable <= '0;
      o_gate_reduce <= '0;
      o_low_io_gate_drive <= '0;
      o_high_io_gate_drive <= '0;
      o_rail12_enable <= '0;
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        // a trip pulse drops the rails in the same edge the latch sets
        o_main_enable[s] <= main_on[s] & ~reg_expire[s] & ~rail_trip[s] & ~aux_trip[s];
        o_rail12_enable[s] <= main_on[s] & ~reg_expire[s] & ~rail_trip[s] & ~aux_trip[s];
        o_gate_reduce[s] <= (reg_mode[s] | i_main_overload[s]) & main_on[s];
        // select picks one gate; both fall together when power goes
        o_low_io_gate_drive[s] <= main_on[s] & ~reg_expire[s] & ~rail_trip[s]
                                  & ~aux_trip[s] & link.slot_io_voltage_select[s];
        o_high_io_gate_drive[s] <= main_on[s] & ~reg_expire[s] & ~rail_trip[s]
                                   & ~aux_trip[s] & ~link.slot_io_voltage_select[s];
      end
    end
  end

  assign link.main_fault = main_fault;
  assign link.aux_fault = aux_fault;
  assign link.regulating = reg_mode;
  assign link.gated_wake_event_oe = wake_oe;
endmodule

// file: hw/hpsc_host.sv
// slot controller: AHB-Lite registers drive requests and collect events
`timescale 1ns/10ps
module hpsc_host (
  input wire logic i_clock, // 125 MHz clock
  input wire logic i_resetn, // async reset, active low
  hpsc_if.host link, // sequencer side
  input wire logic i_hsel, // slave select
  input wire logic [31:0] i_haddr, // byte address
  input wire logic [1:0] i_htrans, // transfer type
  input wire logic i_hwrite, // write when high
  input wire logic [2:0] i_hsize, // transfer size, word only
  input wire logic [31:0] i_hwdata, // write data
  input wire logic i_hready, // bus ready
  output logic o_hreadyout, // slave ready
  output logic [31:0] o_hrdata, // read data
  output logic o_hresp, // response, always okay
  output logic o_irq // level interrupt
);
  import hpsc_pkg::*;

  function automatic logic low_io(input logic [2:0] mode);
    low_io = (mode == MODE_266) || (mode == MODE_533);
  endfunction

  logic acc;
  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr_q;
  logic [31:0] ctrl;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] events;
  logic [NSLOT-1:0] main_fault_q;
  logic [NSLOT-1:0] aux_fault_q;
  logic wake_q;
  logic [31:0] status;
  logic [IRQ_W-1:0] w1c;

  assign acc = i_hsel & i_htrans[1] & i_hready & (i_hsize == 3'h2);
  assign events = {wake_q & ~link.wake_bus_n,
                   link.aux_fault & ~aux_fault_q,
                   link.main_fault & ~main_fault_q};
  assign status = {25'h000_0000, ~link.wake_bus_n, link.regulating, link.aux_fault,
                   link.main_fault};
  assign w1c = (wr_pend && addr_q == OFS_IRQ_STATUS) ? i_hwdata[IRQ_W-1:0] : '0;

  // reads take one wait state so a write just before is already visible
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hrdata <= 32'h0000_0000;
      o_hresp <= 1'b0;
    end else begin
      wr_pend <= acc & i_hwrite;
      rd_pend <= acc & ~i_hwrite;
      o_hresp <= 1'b0;
      if (acc) begin
        addr_q <= i_haddr[7:0];
      end
      o_hreadyout <= ~(acc & ~i_hwrite);
      if (rd_pend) begin
        case (addr_q)
          OFS_CTRL: o_hrdata <= ctrl;
          OFS_STATUS: o_hrdata <= status;
          OFS_IRQ_STATUS: o_hrdata <= {27'h000_0000, irq_status};
          OFS_IRQ_MASK: o_hrdata <= {27'h000_0000, irq_mask};
          default: o_hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control and mask registers
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= CTRL_RESET;
      irq_mask <= '0;
    end else if (wr_pend) begin
      if (addr_q == OFS_CTRL) begin
        ctrl <= i_hwdata & CTRL_MASK;
      end
      if (addr_q == OFS_IRQ_MASK) begin
        irq_mask <= i_hwdata[IRQ_W-1:0];
      end
    end
  end

  // sticky events: a new event wins over a write-one clear
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_status <= '0;
      main_fault_q <= '0;
      aux_fault_q <= '0;
      wake_q <= 1'b1;
      o_irq <= 1'b0;
    end else begin
      main_fault_q <= link.main_fault;
      aux_fault_q <= link.aux_fault;
      wake_q <= link.wake_bus_n;
      irq_status <= (irq_status & ~w1c) | events;
      o_irq <= |(((irq_status & ~w1c) | events) & irq_mask);
    end
  end

  // pins toward the sequencer
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      link.main_power_request <= '0;
      link.slot_io_voltage_select <= '0;
      link.slot_aux_switch_n <= '1;
    end else begin
      link.main_power_request <= ctrl[CTRL_REQ_LSB +: NSLOT];
      link.slot_aux_switch_n <= ~ctrl[CTRL_AUX_LSB +: NSLOT];
      link.slot_io_voltage_select[0] <= low_io(ctrl[CTRL_MODE0_LSB +: 3]);
      link.slot_io_voltage_select[1] <= low_io(ctrl[CTRL_MODE1_LSB +: 3]);
    end
  end
endmodule

// file: hw/hpsc_if.sv
// link between the slot controller and the hot-plug power sequencer
`timescale 1ns/10ps
interface hpsc_if;
  import hpsc_pkg::*;
  logic [NSLOT-1:0] main_power_request;
  logic [NSLOT-1:0] slot_io_voltage_select;
  logic [NSLOT-1:0] slot_aux_switch_n;
  logic [NSLOT-1:0] main_fault;
  logic [NSLOT-1:0] aux_fault;
  logic [NSLOT-1:0] regulating;
  logic [NSLOT-1:0] gated_wake_event_oe;
  logic wake_bus_n;

  // shared open-drain wake node: low while any slot pulls it
  assign wake_bus_n = ~(|gated_wake_event_oe);

  modport device (
    input main_power_request,
    input slot_io_voltage_select,
    input slot_aux_switch_n,
    output main_fault,
    output aux_fault,
    output regulating,
    output gated_wake_event_oe
  );
  modport host (
    output main_power_request,
    output slot_io_voltage_select,
    output slot_aux_switch_n,
    input main_fault,
    input aux_fault,
    input regulating,
    input wake_bus_n
  );
endinterface

// file: hw/hpsc_pkg.sv
// shared constants for the two-slot hot-plug fault and wake-event control
package hpsc_pkg;
  localparam int NSLOT = 2;
  localparam int CNT_W = 20;
  localparam int CLK_MHZ = 125;

  // timing figures in their own units, and their cycle counts
  localparam int REG_HOLD_MS = 5;
  localparam int REG_CLEAR_US = 100;
  localparam int FAST_TRIP_US = 3;
  localparam int REG_HOLD_CYCLES = REG_HOLD_MS * 1000 * CLK_MHZ;
  localparam int REG_CLEAR_CYCLES = REG_CLEAR_US * CLK_MHZ + 1;
  localparam int FAST_TRIP_CYCLES = FAST_TRIP_US * CLK_MHZ;
  localparam int AUX_RAMP_CYCLES = 1000;
  localparam int WAKE_DELAY_CYCLES = 1000;

  // slot bus modes, as set by software in the controller
  localparam logic [2:0] MODE_33 = 3'h0;
  localparam logic [2:0] MODE_66 = 3'h1;
  localparam logic [2:0] MODE_133 = 3'h2;
  localparam logic [2:0] MODE_266 = 3'h3;
  localparam logic [2:0] MODE_533 = 3'h4;

  // controller register map (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

  // control register fields
  localparam int CTRL_REQ_LSB = 0;
  localparam int CTRL_AUX_LSB = 2;
  localparam int CTRL_MODE0_LSB = 4;
  localparam int CTRL_MODE1_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_077F;

  // status and interrupt fields
  localparam int ST_MAIN_LSB = 0;
  localparam int ST_AUX_LSB = 2;
  localparam int ST_REG_LSB = 4;
  localparam int ST_WAKE_BIT = 6;
  localparam int IRQ_W = 5;
  localparam int IRQ_MAIN_LSB = 0;
  localparam int IRQ_AUX_LSB = 2;
  localparam int IRQ_WAKE_BIT = 4;
endpackage
